// >>> hdl/pos_map.vh
// constants for the pixel output timing stage
// assumes inclusion by bare name from the design files
`ifndef POS_MAP_VH
`define POS_MAP_VH

`define POS_REG_SYNC_WIDTH   8'h23
`define POS_REG_SYNC_CONFIG  8'h24
`define POS_SYNC_POL_BIT     7
`define POS_PIPE_FLUSH       23
`define POS_PHASE_STEPS      32
`define POS_PHASE_BITS       5
`define POS_PHASE_MDEG       11250
`define POS_SYNC_WIDTH_RST   8'h20
`define POS_RANGE0_LO        8'h0c
`define POS_RANGE0_HI        8'h1e
`define POS_RANGE1_LO        8'h1e
`define POS_RANGE1_HI        8'h3c
`define POS_RANGE2_LO        8'h3c
`define POS_RANGE2_HI        8'h78
`define POS_RANGE3_LO        8'h78
`define POS_RANGE3_HI        8'h96

`endif

// >>> hdl/pos_sync3.v
// three-stage synchroniser for inputs from outside the clk_sys domain
// output follows once the second and third stages agree
`timescale 1ns/1ps
module pos_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] stableOut
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer i;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1_q  <= {WIDTH{1'b0}};
            stage2_q  <= {WIDTH{1'b0}};
            stage3_q  <= {WIDTH{1'b0}};
            stableOut <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    stableOut[i] <= stage3_q[i];
                end
            end
        end
    end
endmodule

// >>> hdl/pos_pixel_output.v
// pixel output timing stage: phase-shifted sampling, output pixel clock,
// regenerated line sync, pipeline flush tracking, pll range settings
// assumes pixel clock, line sync and pixel data arrive as pins sampled
// by clk_sys, with a pixel period of at least 4 clk_sys cycles
// Notes on behaviour
// - output clock rises midway between output data changes
// - first 23 data sets are flagged invalid; receiver discards them
// - input line-sync polarity found automatically from high/low lengths
// - output line sync polarity chosen by bit 7 of register 0x24
// - output line sync pulse changes together with data and output clock; idle level follows the polarity bit at once
// - output line sync active for line_sync_out_width pixel clocks
// - sampling phase shiftable across one period in 32 steps
// - range code selects one of four overlapping pixel-rate regions
// - each step 11.25 degrees; line sync carries same shift
`timescale 1ns/1ps
`include "pos_map.vh"
module pos_pixel_output #(
    parameter DATA_WIDTH = 24,
    parameter CNT_WIDTH  = 8
) (
    input  wire                  clk_sys,
    input  wire                  rst,
    input  wire                  pixelClockIn,
    input  wire                  lineSyncIn,
    input  wire [DATA_WIDTH-1:0] pixelDataIn,
    input  wire [7:0]            lineSyncOutWidth,
    input  wire [7:0]            syncConfig,
    input  wire [4:0]            phaseStep,
    input  wire [1:0]            oscillatorRangeCode,
    input  wire [2:0]            chargePumpCode,
    output reg  [DATA_WIDTH-1:0] pixelDataOut,
    output reg                   outputPixelClock,
    output reg                   lineSyncOut,
    output reg                   dataValid,
    output reg                   inputSyncActiveHigh,
    output reg  [1:0]            pllRangeOut,
    output reg  [2:0]            pllCurrentOut,
    output reg  [7:0]            rateRangeLowMhz,
    output reg  [7:0]            rateRangeHighMhz
);
    wire                  pixClkS;
    wire                  lineSyncS;
    wire [DATA_WIDTH-1:0] pixDataS;

    pos_sync3 #(.WIDTH(DATA_WIDTH + 2)) uSync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .asyncIn   ({pixelClockIn, lineSyncIn, pixelDataIn}),
        .stableOut ({pixClkS, lineSyncS, pixDataS})
    );

    reg                   pixClkPrev_q;
    reg                   lineSyncPrev_q;
    reg [CNT_WIDTH-1:0]   sinceEdge_q;
    reg [CNT_WIDTH-1:0]   period_q;
    reg [15:0]            highLen_q;
    reg [15:0]            lowLen_q;
    reg                   syncPending_q;
    reg [7:0]             pulseLeft_q;
    reg                   pulseOn_q;
    reg [4:0]             flushCnt_q;

    wire pixEdge  = pixClkS & ~pixClkPrev_q;
    wire syncRise = lineSyncS & ~lineSyncPrev_q;

    // phase delay = period * step / 32 clk_sys cycles
    wire [CNT_WIDTH+4:0] phaseProd = period_q * phaseStep;
    wire [CNT_WIDTH-1:0] phaseDelay =
        phaseProd[CNT_WIDTH+4:`POS_PHASE_BITS];
    wire [CNT_WIDTH:0]   halfSum = {1'b0, phaseDelay}
                                 + {2'b00, period_q[CNT_WIDTH-1:1]};
    wire [CNT_WIDTH-1:0] halfPoint = (halfSum >= {1'b0, period_q})
        ? halfSum[CNT_WIDTH-1:0] - period_q
        : halfSum[CNT_WIDTH-1:0];
    // no sample strobe until a pixel edge has given a period
    wire sampleStrobe = (sinceEdge_q == phaseDelay)
                     && (period_q != {CNT_WIDTH{1'b0}});
    wire riseStrobe   = (sinceEdge_q == halfPoint) && !sampleStrobe;

    wire syncActiveIn  = (lineSyncS == inputSyncActiveHigh);
    wire syncActivePrv = (lineSyncPrev_q == inputSyncActiveHigh);
    wire syncLead      = syncActiveIn && !syncActivePrv;
    wire outActive     = syncConfig[`POS_SYNC_POL_BIT];

    // pixel period measurement and phase-shifted strobes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pixClkPrev_q <= 1'b0;
            sinceEdge_q  <= {CNT_WIDTH{1'b0}};
            period_q     <= {CNT_WIDTH{1'b0}};
        end else begin
            pixClkPrev_q <= pixClkS;
            if (pixEdge) begin
                sinceEdge_q <= {CNT_WIDTH{1'b0}};
                period_q    <= sinceEdge_q + 1'b1;
            end else if (sinceEdge_q != {CNT_WIDTH{1'b1}}) begin
                sinceEdge_q <= sinceEdge_q + 1'b1;
            end
        end
    end

    // input polarity: active level is the shorter part of the line
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lineSyncPrev_q      <= 1'b0;
            highLen_q           <= 16'h0000;
            lowLen_q            <= 16'h0000;
            inputSyncActiveHigh <= 1'b1;
        end else begin
            lineSyncPrev_q <= lineSyncS;
            if (syncRise) begin
                inputSyncActiveHigh <= (highLen_q < lowLen_q);
                highLen_q           <= 16'h0000;
                lowLen_q            <= 16'h0000;
            end else if (lineSyncS) begin
                if (highLen_q != 16'hffff) begin
                    highLen_q <= highLen_q + 16'h0001;
                end
            end else if (lowLen_q != 16'hffff) begin
                lowLen_q <= lowLen_q + 16'h0001;
            end
        end
    end

    // data, output clock fall and regenerated line sync pulse move on one strobe; clock rises on riseStrobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pixelDataOut     <= {DATA_WIDTH{1'b0}};
            outputPixelClock <= 1'b0;
            lineSyncOut      <= 1'b0;
            syncPending_q    <= 1'b0;
            pulseLeft_q      <= 8'h00;
            pulseOn_q        <= 1'b0;
            flushCnt_q       <= 5'h00;
            dataValid        <= 1'b0;
        end else begin
            if (sampleStrobe) begin
                pixelDataOut     <= pixDataS;
                outputPixelClock <= 1'b0;
                if (flushCnt_q < `POS_PIPE_FLUSH) begin
                    flushCnt_q <= flushCnt_q + 5'h01;
                    dataValid  <= 1'b0;
                end else begin
                    dataValid <= 1'b1;
                end
                if (syncPending_q && lineSyncOutWidth != 8'h00) begin
                    pulseLeft_q <= lineSyncOutWidth - 8'h01;
                    lineSyncOut <= outActive;
                    pulseOn_q   <= 1'b1;
                end else if (pulseLeft_q != 8'h00) begin
                    pulseLeft_q <= pulseLeft_q - 8'h01;
                    lineSyncOut <= outActive;
                    pulseOn_q   <= 1'b1;
                end else begin
                    lineSyncOut <= ~outActive;
                    pulseOn_q   <= 1'b0;
                end
            end else begin
                if (riseStrobe) begin
                    outputPixelClock <= 1'b1;
                end
                // idle only: a running pulse ends on a strobe
                if (!pulseOn_q) begin
                    lineSyncOut <= ~outActive;
                end
            end
            // a new leading edge wins over the strobe that clears
            if (syncLead) begin
                syncPending_q <= 1'b1;
            end else if (sampleStrobe) begin
                syncPending_q <= 1'b0;
            end
        end
    end

    // pll range and charge pump settings, with rate region decode
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pllRangeOut      <= 2'b00;
            pllCurrentOut    <= 3'b000;
            rateRangeLowMhz  <= `POS_RANGE0_LO;
            rateRangeHighMhz <= `POS_RANGE0_HI;
        end else begin
            pllRangeOut   <= oscillatorRangeCode;
            pllCurrentOut <= chargePumpCode;
            case (oscillatorRangeCode)
                2'b00: begin
                    rateRangeLowMhz  <= `POS_RANGE0_LO;
                    rateRangeHighMhz <= `POS_RANGE0_HI;
                end
                2'b01: begin
                    rateRangeLowMhz  <= `POS_RANGE1_LO;
                    rateRangeHighMhz <= `POS_RANGE1_HI;
                end
                2'b10: begin
                    rateRangeLowMhz  <= `POS_RANGE2_LO;
                    rateRangeHighMhz <= `POS_RANGE2_HI;
                end
                default: begin
                    rateRangeLowMhz  <= `POS_RANGE3_LO;
                    rateRangeHighMhz <= `POS_RANGE3_HI;
                end
            endcase
        end
    end
endmodule

// >>> verif/pos_props.sv
// assertions on the pixel output stage ports
// bound into every pos_pixel_output instance
`timescale 1ns/1ps
module pos_props #(
    parameter DATA_WIDTH = 24
) (
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic [7:0]            lineSyncOutWidth,
    input wire logic [7:0]            syncConfig,
    input wire logic [1:0]            oscillatorRangeCode,
    input wire logic [DATA_WIDTH-1:0] pixelDataOut,
    input wire logic                  outputPixelClock,
    input wire logic                  lineSyncOut,
    input wire logic                  dataValid,
    input wire logic [1:0]            pllRangeOut,
    input wire logic [7:0]            rateRangeLowMhz,
    input wire logic [7:0]            rateRangeHighMhz
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence sStrobe;
        $fell(outputPixelClock);
    endsequence
    wire       syncOn = lineSyncOut == syncConfig[7];
    reg  [7:0] onCnt_q;
    // strobes seen while the output sync is active
    always @(posedge clk_sys or posedge rst)
        if (rst)
            onCnt_q <= 8'h00;
        else if (!syncOn)
            onCnt_q <= 8'h00;
        else if ($fell(outputPixelClock))
            onCnt_q <= onCnt_q + 8'h01;
    a_data_rise: assert property (
        $rose(outputPixelClock) |-> $stable(pixelDataOut))
        else $error("data moved at clock rise");
    a_clk_low: assert property (
        sStrobe |=> !outputPixelClock) else $error("clock high too soon");
    a_sync_aligned: assert property (
        $changed(lineSyncOut) && !$past(rst, 2)
        && syncConfig == $past(syncConfig, 2) |-> sStrobe)
        else $error("sync moved off strobe");
    a_valid_hold: assert property (
        dataValid |=> dataValid) else $error("valid dropped");
    a_valid_strobe: assert property (
        $rose(dataValid) |-> sStrobe) else $error("valid off strobe");
    a_sync_width: assert property (
        $fell(syncOn) && !$past(rst, 2) && syncConfig == $past(syncConfig, 2)
        |-> onCnt_q == lineSyncOutWidth) else $error("sync width wrong");
    a_range_copy: assert property (
        1'b1 |=> pllRangeOut == $past(oscillatorRangeCode))
        else $error("range code lost");
    a_rate_low: assert property (
        pllRangeOut == 2'b00 |-> rateRangeLowMhz == 8'h0c
        && rateRangeHighMhz == 8'h1e) else $error("region bounds wrong");
endmodule
bind pos_pixel_output pos_props #(.DATA_WIDTH(DATA_WIDTH)) i_props (.clk_sys,
    .rst, .lineSyncOutWidth, .syncConfig, .oscillatorRangeCode, .pixelDataOut,
    .outputPixelClock, .lineSyncOut, .dataValid, .pllRangeOut,
    .rateRangeLowMhz, .rateRangeHighMhz);

// >>> verif/pos_receiver.sv
// receiver model: takes words on output clock rise, counts lines
// assumes it watches the outputs of pos_pixel_output
`timescale 1ns/1ps
module pos_receiver (
    input  wire logic        outputPixelClock,
    input  wire logic [23:0] pixelDataOut,
    input  wire logic        dataValid,
    input  wire logic        lineSyncOut,
    input  wire logic        activeLevel,
    output int               errCnt = 0,
    output int               lineCnt = 0
);
    logic [23:0] last = 24'h0;
    // flush words dropped; valid words must run in sequence
    always @(posedge outputPixelClock) begin
        if (dataValid === 1'b1 && last != 24'h0 && pixelDataOut !== last + 24'h1)
            errCnt++;
        if (dataValid === 1'b1)
            last = pixelDataOut;
    end
    always @(posedge (lineSyncOut === activeLevel)) lineCnt++;
endmodule

// >>> verif/test_pos_pixel_output.sv
// bench for pos_pixel_output: link stimulus, receiver model, checks
// assumes pos_props is bound through its own file
`timescale 1ns/1ps
module test_pos_pixel_output;
    logic        clk_sys = 0, rst = 1, pixelClockIn = 0, lineSyncIn = 0;
    logic        inHigh = 1, p, outputPixelClock, lineSyncOut, dataValid;
    logic        inputSyncActiveHigh;
    logic [23:0] pixelDataIn = 24'h100000, pixelDataOut, last;
    logic [7:0]  lineSyncOutWidth = 8'h03, syncConfig = 8'h80;
    logic [7:0]  rateRangeLowMhz, rateRangeHighMhz;
    logic [7:0]  lo [4] = '{8'h0c, 8'h1e, 8'h3c, 8'h78};
    logic [7:0]  hi [4] = '{8'h1e, 8'h3c, 8'h78, 8'h96};
    logic [4:0]  phaseStep = 5'h00;
    logic [1:0]  oscillatorRangeCode = 2'h0, pllRangeOut;
    logic [2:0]  chargePumpCode = 3'h5, pllCurrentOut;
    int          mismatches = 0, total_checks = 0, errCnt, lineCnt, n, d, d0;
    int          pixCnt = 0;
    pos_pixel_output i_dut (.clk_sys, .rst, .pixelClockIn, .lineSyncIn,
        .pixelDataIn, .lineSyncOutWidth, .syncConfig, .phaseStep,
        .oscillatorRangeCode, .chargePumpCode, .pixelDataOut, .outputPixelClock,
        .lineSyncOut, .dataValid, .inputSyncActiveHigh, .pllRangeOut,
        .pllCurrentOut, .rateRangeLowMhz, .rateRangeHighMhz);
    pos_receiver i_rx (.outputPixelClock, .pixelDataOut, .dataValid,
        .lineSyncOut, .activeLevel(syncConfig[7]), .errCnt, .lineCnt);
    initial forever #20 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #160 pixelClockIn = ~pixelClockIn;
    end
    always @(negedge pixelClockIn) begin
        pixCnt <= pixCnt + 1;
        pixelDataIn <= 24'h100000 + pixCnt[23:0];
        lineSyncIn <= ((pixCnt % 40) < 4) ~^ inHigh;
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic waitLines(input int k);
        n = lineCnt + k;
        repeat (6000) if (lineCnt < n) @(posedge clk_sys);
        if (lineCnt < n) begin
            mismatches++;
            final_report;
        end
    endtask
    task automatic measure(output int dl);
        @(posedge pixelClockIn);
        dl = 0;
        do begin
            p = outputPixelClock;
            @(posedge clk_sys);
            #1;
            dl++;
        end while (!(p === 1'b1 && outputPixelClock === 1'b0) && dl < 20);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        n = 0;
        for (int i = 0; i < 4000 && dataValid !== 1'b1; i++) begin
            last = pixelDataOut;
            @(posedge clk_sys);
            #1;
            if (dataValid !== 1'b1 && pixelDataOut !== last) n++;
        end
        check(n[23:0], 24'd23);
        for (int c = 0; c < 5; c++) begin
            waitLines(4);
            repeat (48) @(posedge clk_sys);
            #1;
            check({23'h0, ~syncConfig[7]}, {23'h0, lineSyncOut});
            check({23'h0, inHigh}, {23'h0, inputSyncActiveHigh});
            @(posedge clk_sys);
            syncConfig <= {c[0], 7'h00};
            inHigh <= c[1];
        end
        check(errCnt[23:0], 24'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            phaseStep <= (k == 3) ? 5'h1f : 5'(k * 8);
            repeat (40) @(posedge clk_sys);
            measure(d);
            if (k == 0) d0 = d;
            check(24'((d - d0 + 16) % 8), 24'(phaseStep / 4));
        end
        for (int r = 0; r < 4; r++) begin
            @(posedge clk_sys);
            oscillatorRangeCode <= r[1:0];
            chargePumpCode <= (r == 3) ? 3'h6 : 3'h5;
            repeat (2) @(posedge clk_sys);
            #1;
            check({21'h0, pllCurrentOut}, (r == 3) ? 24'h6 : 24'h5);
            check({16'h0, rateRangeLowMhz}, {16'h0, lo[r]});
            check({16'h0, rateRangeHighMhz}, {16'h0, hi[r]});
        end
        final_report;
    end
endmodule
